/* rsmu_map.vh */
// Register offsets, field positions and codes of the rotate/shift unit.
`ifndef RSMU_MAP_VH
`define RSMU_MAP_VH
// ==========================================
// Register byte offsets
`define OFS_SRC     8'h00
`define OFS_DST     8'h04
`define OFS_CNT     8'h08
`define OFS_CTRL    8'h0c
`define OFS_COND    8'h10
`define OFS_EXC     8'h14
// ==========================================
// Control register fields
`define CT_OP_HI    2
`define CT_OP_LO    0
`define CT_REC      3
`define CT_SHAMT_HI 8
`define CT_SHAMT_LO 4
`define CT_MBEG_HI  13
`define CT_MBEG_LO  9
`define CT_MEND_HI  18
`define CT_MEND_LO  14
`define CT_W        19
// ==========================================
// Operation codes
`define OP_RIAND    3'h0
`define OP_RRAND    3'h1
`define OP_RIINS    3'h2
`define OP_SLL      3'h3
`define OP_SRL      3'h4
`define OP_SRAR     3'h5
`define OP_SRAI     3'h6
// ==========================================
// Condition field bits (0 is less, 1 greater, 2 equal, 3 kept as written)
`define CR_LT       3
`define CR_GT       2
`define CR_EQ       1
// Exception register bits.
`define XR_CA       0
`define XR_OV       1
`define XR_SO       2
// Reset values.
`define RST_WORD    32'h0000_0000
`define RST_CTRL    19'h0_0000
`define RST_COND    4'h0
`define RST_EXC     3'h0
// Index helpers.
`define TOP_BIT     31
`define CNT_BIG     5
// Top bit of the rotate count, of the shift count and of the flag fields.
`define CNT_ROT_HI  4
`define CNT_SHF_HI  5
`define COND_HI     3
`define EXC_HI      2
`endif

/* rotate_shift_mask_unit.v */
// Rotate, shift and mask datapath with an APB register file.
`timescale 1ns/100ps
`default_nettype none
`include "rsmu_map.vh"

module rotate_shift_mask_unit (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr
);

  // ==========================================
  // State registers
  // Bit numbering: documented position p sits at vector bit 31-p.
  reg [31:0]      src_q;   // Source word.
  reg [31:0]      dst_q;   // Destination word, also insert base.
  reg [31:0]      cnt_q;   // Count word for register-count forms.
  reg [`CT_W-1:0] ctrl_q;  // Last operation written.
  reg [3:0]       cond_q;  // First condition field.
  reg [2:0]       fixed_point_exception_reg_q;  // Carry and overflows.

  // ==========================================
  // Decode of the access phase
  wire       acc_w;       // Write completes this edge.
  wire [2:0] op;          // Operation code from write data.
  wire       rec;         // Record form requested.
  wire [4:0] shift_amount_field;  // Shift amount field.
  wire [4:0] mask_begin_field;    // Mask begin field.
  wire [4:0] mask_end_field;      // Mask end field.

  // The slave answers in the first access cycle.
  assign pready = 1'b1;
  assign acc_w  = psel & penable & pwrite;
  assign op  = pwdata[`CT_OP_HI:`CT_OP_LO];
  assign rec = pwdata[`CT_REC];
  assign shift_amount_field = pwdata[`CT_SHAMT_HI:`CT_SHAMT_LO];
  assign mask_begin_field   = pwdata[`CT_MBEG_HI:`CT_MBEG_LO];
  assign mask_end_field     = pwdata[`CT_MEND_HI:`CT_MEND_LO];

  // ==========================================
  // Mask generator
  reg [31:0] mask;        // Generated mask.
  integer    p;           // Documented bit position.

  // Builds ones from begin to end, wrapping when begin is larger.
  always @* begin
    mask = `RST_WORD;
    for (p = 0; p <= `TOP_BIT; p = p + 1) begin
      if (mask_begin_field <= mask_end_field) begin
        // Plain run from begin through end inclusive.
        mask[`TOP_BIT-p] = (p >= mask_begin_field) &&
                           (p <= mask_end_field);
      end else begin
        // Wrapped run: begin to 31 and 0 to end.
        mask[`TOP_BIT-p] = (p >= mask_begin_field) ||
                           (p <= mask_end_field);
      end
    end
    // Begin always lies in the run, so one bit is always set.
  end

  // ==========================================
  // Rotator
  reg  [4:0]  rot_n;      // Rotate count.
  wire [63:0] rot_dbl;    // Doubled word shifted toward the top.
  wire [31:0] rot;        // Rotated source.

  // Selects immediate field or low five bits of the count word.
  always @* begin
    if (op == `OP_RRAND) begin
      rot_n = cnt_q[`CNT_ROT_HI:0];
    end else begin
      rot_n = shift_amount_field;
    end
  end

  // Bits leaving the top re-enter at the bottom.
  assign rot_dbl = {src_q, src_q} << rot_n;
  assign rot     = rot_dbl[63:32];

  // ==========================================
  // Shifter
  reg  [5:0]  shf_n;      // Shift count, six bits.
  wire        sign;       // Source sign, documented bit 0.
  wire [31:0] sll_v;      // Logical left result.
  wire [31:0] srl_v;      // Logical right result.
  wire [31:0] sra_v;      // Arithmetic right result.
  wire [31:0] sra_sh;     // Sign-filling shift for counts below 32.
  wire [31:0] lost;       // Mask of bits shifted out on the right.
  wire        ca_v;       // Carry from arithmetic right shift.

  // Immediate arithmetic form takes the shift field.
  always @* begin
    if (op == `OP_SRAI) begin
      shf_n = {1'b0, shift_amount_field};
    end else begin
      shf_n = cnt_q[`CNT_SHF_HI:0];
    end
  end

  assign sign  = src_q[`TOP_BIT];
  // Counts of 32 or more clear or fill the whole word.
  // The signed shift stands alone: an unsigned arm of the select below
  // would turn it into a logical shift and lose the sign fill.
  assign sra_sh = $signed(src_q) >>> shf_n[`CNT_ROT_HI:0];
  assign sll_v = shf_n[`CNT_BIG] ? `RST_WORD :
                 (src_q << shf_n[`CNT_ROT_HI:0]);
  assign srl_v = shf_n[`CNT_BIG] ? `RST_WORD :
                 (src_q >> shf_n[`CNT_ROT_HI:0]);
  assign sra_v = shf_n[`CNT_BIG] ? {32{sign}} :
                 sra_sh;
  assign lost  = shf_n[`CNT_BIG] ? ~`RST_WORD :
                 ~(~`RST_WORD << shf_n[`CNT_ROT_HI:0]);
  // Carry is set when a negative source loses any one bit on the right.
  assign ca_v  = sign & (|(src_q & lost));

  // ==========================================
  // Result select
  reg [31:0] res;         // Final destination value.
  reg        valid_op;    // Code is a known operation.
  reg        is_sra;      // Operation is an arithmetic right shift.

  // Chooses the result for the requested operation.
  always @* begin
    res      = dst_q;
    valid_op = 1'b1;
    is_sra   = 1'b0;
    case (op)
      `OP_RIAND: begin
        res = rot & mask;
      end
      `OP_RRAND: begin
        res = rot & mask;
      end
      `OP_RIINS: begin
        res = (rot & mask) | (dst_q & ~mask);
      end
      `OP_SLL: begin
        res = sll_v;
      end
      `OP_SRL: begin
        res = srl_v;
      end
      `OP_SRAR: begin
        res    = sra_v;
        is_sra = 1'b1;
      end
      `OP_SRAI: begin
        res    = sra_v;
        is_sra = 1'b1;
      end
      default: begin
        // Unknown code does nothing.
        valid_op = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Address decode
  wire hit_src;           // Source register selected.
  wire hit_dst;           // Destination register selected.
  wire hit_cnt;           // Count register selected.
  wire hit_ctrl;          // Control register selected.
  wire hit_cond;          // Condition register selected.
  wire hit_exc;           // Exception register selected.
  wire hit_any;           // Some register selected.
  wire run;               // Operation executes this edge.

  assign hit_src  = (paddr == `OFS_SRC);
  assign hit_dst  = (paddr == `OFS_DST);
  assign hit_cnt  = (paddr == `OFS_CNT);
  assign hit_ctrl = (paddr == `OFS_CTRL);
  assign hit_cond = (paddr == `OFS_COND);
  assign hit_exc  = (paddr == `OFS_EXC);
  assign hit_any  = hit_src | hit_dst | hit_cnt | hit_ctrl |
                    hit_cond | hit_exc;
  assign run      = acc_w & hit_ctrl & valid_op;

  // ==========================================
  // Read data and error answer
  reg [31:0] rd_mux;      // Register selected by the address.

  // Read mux, unmapped addresses read zero with an error.
  always @* begin
    pslverr = psel & penable & ~hit_any;
    rd_mux  = `RST_WORD;
    if (hit_src) begin
      rd_mux = src_q;
    end else if (hit_dst) begin
      rd_mux = dst_q;
    end else if (hit_cnt) begin
      rd_mux = cnt_q;
    end else if (hit_ctrl) begin
      rd_mux = {{(`TOP_BIT+1-`CT_W){1'b0}}, ctrl_q};
    end else if (hit_cond) begin
      rd_mux = {{(`TOP_BIT-`COND_HI){1'b0}}, cond_q};
    end else if (hit_exc) begin
      rd_mux = {{(`TOP_BIT-`EXC_HI){1'b0}}, fixed_point_exception_reg_q};
    end
  end

  // Read data is taken in the setup cycle, when no write can land, so the
  // port is driven from a flip-flop for the whole access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_WORD;
    end else if (psel & ~penable & ~pwrite) begin
      // Setup cycle of a read: capture the addressed register.
      prdata <= rd_mux;
    end
  end

  // ==========================================
  // Operand registers
  // Software loads source and count words.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q  <= `RST_WORD;
      cnt_q  <= `RST_WORD;
      ctrl_q <= `RST_CTRL;
    end else begin
      if (acc_w & hit_src) begin
        src_q <= pwdata;
      end
      if (acc_w & hit_cnt) begin
        cnt_q <= pwdata;
      end
      if (acc_w & hit_ctrl) begin
        ctrl_q <= pwdata[`CT_W-1:0];
      end
    end
  end

  // ==========================================
  // Destination register
  // Takes software writes or the result of an operation.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_q <= `RST_WORD;
    end else if (run) begin
      dst_q <= res;
    end else if (acc_w & hit_dst) begin
      dst_q <= pwdata;
    end
  end

  // ==========================================
  // Condition field
  // Record forms compare the final result with zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_q <= `RST_COND;
    end else if (run & rec) begin
      // Bit 3 is left alone; bits 0-2 follow the result.
      cond_q[`CR_LT] <= res[`TOP_BIT];
      cond_q[`CR_GT] <= ~res[`TOP_BIT] & (|res);
      cond_q[`CR_EQ] <= ~(|res);
    end else if (acc_w & hit_cond) begin
      // Plain forms never reach here with run set.
      cond_q <= pwdata[`COND_HI:0];
    end
  end

  // ==========================================
  // Exception register
  // Operations touch only carry, and only arithmetic right shifts do so.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_point_exception_reg_q <= `RST_EXC;
    end else if (run) begin
      if (is_sra) begin
        fixed_point_exception_reg_q[`XR_CA] <= ca_v;
      end
      // Overflow bits keep their value.
    end else if (acc_w & hit_exc) begin
      fixed_point_exception_reg_q <= pwdata[`EXC_HI:0];
    end
  end

endmodule
`default_nettype wire

/* rsmu_checker.sv */
// Bus-side assertions for the rotate, shift and mask unit.
`timescale 1ns/100ps
`default_nettype none
module rsmu_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // =====
  // Shadows of the flag bits that only software should move.
  logic [1:0] ovso_q;  // Last written overflow pair.
  logic [3:0] cond_q;  // Last written condition field.
  logic       ca_q;    // Last written carry.
  logic       cok_q;   // No record operation since the condition write.
  logic       aok_q;   // No arithmetic shift since the carry write.
  wire acc = psel && penable;
  wire wr  = acc && pwrite;
  wire rd  = acc && !pwrite;
  wire map = (paddr[1:0] == 2'h0) && (paddr <= 8'h14);
  wire ar  = (pwdata[2:0] == 3'h5) || (pwdata[2:0] == 3'h6);
  // Shadows follow every write to the condition, exception and control registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovso_q <= 2'h0;
      cond_q <= 4'h0;
      ca_q   <= 1'b0;
      cok_q  <= 1'b1;
      aok_q  <= 1'b1;
    end else if (wr && paddr == 8'h10) begin
      cond_q <= pwdata[3:0];
      cok_q  <= 1'b1;
    end else if (wr && paddr == 8'h14) begin
      ovso_q <= pwdata[2:1];
      ca_q   <= pwdata[0];
      aok_q  <= 1'b1;
    end else if (wr && paddr == 8'h0c) begin
      cok_q  <= cok_q && !(pwdata[3] && pwdata[2:0] != 3'h7);
      aok_q  <= aok_q && !ar;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  bad_addr_err_a: assert property (acc && !map |-> pslverr)
    else $error("no error on an unmapped address");
  bad_addr_zero_a: assert property (rd && !map |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  good_addr_ok_a: assert property (acc && map |-> !pslverr)
    else $error("error on a mapped address");
  flag_width_a: assert property (rd && paddr == 8'h14 |-> prdata[31:3] == 0)
    else $error("upper flag bits not zero");
  ov_so_kept_a: assert property (
    rd && paddr == 8'h14 |-> prdata[2:1] == ovso_q)
    else $error("overflow bits moved by an operation");
  carry_kept_a: assert property (
    rd && paddr == 8'h14 && aok_q |-> prdata[0] == ca_q)
    else $error("carry moved without an arithmetic shift");
  cond_kept_a: assert property (
    rd && paddr == 8'h10 && cok_q |-> prdata[3:0] == cond_q)
    else $error("condition moved without record form");
  cond_spare_a: assert property (
    rd && paddr == 8'h10 |-> prdata[0] == cond_q[0])
    else $error("condition bit beyond the three moved");
endmodule
`default_nettype wire

/* apb_master_model.sv */
// Issue-side partner that reaches the unit's registers over APB.
`timescale 1ns/100ps
`default_nettype none
module apb_master_model (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // =====
  // Bus idles with nothing selected.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer: setup, then access held until pready is seen high, for at most 20 cycles.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output logic ok);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the rotate, shift and mask unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, rec, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, src, dst, cnt, res, rd_v, lost, rot, msk;
  logic [3:0]  cond;
  logic [2:0]  fixed_point_exception_reg, op;
  logic [4:0]  shift_amount_field, mask_begin_field, mask_end_field;
  int          n_fail = 0;
  int          num_checks = 0;
  int          sa;
  always #25 pclk = ~pclk;
  apb_master_model bus_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  rotate_shift_mask_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // =====
  // Verdict and end of run.
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus access; a hung transfer ends the run.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    bus_u.xfer(w, a, d, rd_v, err, ok);
    if (!ok) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  function automatic logic [31:0] rotl(logic [31:0] x, int n);
    return (n == 0) ? x : ((x << n) | (x >> (32 - n)));
  endfunction
  // Mask in the left-to-right bit numbering, wrapping when begin > end.
  function automatic logic [31:0] mk(int b, int e);
    logic [31:0] m = 32'h0;
    for (int p = 0; p < 32; p++)
      if ((b <= e) ? (p >= b && p <= e) : (p >= b || p <= e)) m[31-p] = 1'b1;
    return m;
  endfunction
  // =====
  // Reset values, random operations, then unmapped accesses.
  initial begin
    void'($urandom(90));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      check("reset", rd_v, 32'h0);
    end
    for (int i = 0; i < 96; i++) begin
      op = 3'(i % 8);
      {rec, shift_amount_field, mask_begin_field, mask_end_field} =
        16'($urandom);
      src = $urandom;
      cnt = (i == 13) ? 32'h20 : $urandom;
      dst = $urandom;
      if (i % 4 == 0) begin
        cond = 4'($urandom);
        fixed_point_exception_reg = 3'($urandom);
        bus(1'b1, 8'h10, {28'h0, cond});
        bus(1'b1, 8'h14, {29'h0, fixed_point_exception_reg});
      end
      bus(1'b1, 8'h00, src);
      bus(1'b1, 8'h04, dst);
      bus(1'b1, 8'h08, cnt);
      bus(1'b1, 8'h0c, {13'h0, mask_end_field, mask_begin_field,
                        shift_amount_field, rec, op});
      sa = (op == 3'h6) ? int'(shift_amount_field) : int'(cnt[5:0]);
      lost = src & ((32'h1 << sa) - 32'h1);
      rot = rotl(src, shift_amount_field);
      msk = mk(mask_begin_field, mask_end_field);
      case (op)
        3'h0: res = rot & msk;
        3'h1: res = rotl(src, cnt[4:0]) & msk;
        3'h2: res = (rot & msk) | (dst & ~msk);
        3'h3: res = src << cnt[5:0];
        3'h4: res = src >> cnt[5:0];
        3'h7: res = dst;
        default: begin
          res = $signed(src) >>> sa;
          fixed_point_exception_reg[0] = src[31] & (|lost);
        end
      endcase
      if (rec && op != 3'h7)
        cond = {$signed(res) < 0, $signed(res) > 0, res == 0, cond[0]};
      bus(1'b0, 8'h04, 32'h0);
      check("dst", rd_v, res);
      bus(1'b0, 8'h10, 32'h0);
      check("cond", rd_v, {28'h0, cond});
      bus(1'b0, 8'h14, 32'h0);
      check("flags", rd_v, {29'h0, fixed_point_exception_reg});
    end
    bus(1'b0, 8'h18, 32'h0);
    check("bad_rd", {rd_v[31:1], err}, 32'h1);
    bus(1'b1, 8'h40, 32'hffffffff);
    check("bad_wr", {31'h0, err}, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    check("src", rd_v, src);
    report_and_stop();
  end
endmodule
bind rotate_shift_mask_unit rsmu_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
